// >>> cssm_clock_switch.sv
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Function
// - Crystal runs whenever its enable bit set
// - Crystal is clock only group 000 enabled
// - PLL offers x4, x8, x16 factors
// - Lock bit follows PLL lock
// - Group 001 selects fast RC
// - Four-bit signed trim code, 1.5% steps
// - Group 111 fuse codes pick fast RC PLL
// - Slow RC enabled at power-on
// - Slow RC stops after delay unless needed
// - Monitor keeps slow RC on outside sleep, ignores watchdog bit
// - Failure traps, selects fast RC, flags, clears request
// - Watchdog unaffected by clock failure
// - Delay expiry before oscillator start is failure
// - Switch only among five groups
// - Current group read only, requested writable
// - Reset loads both groups from fuses
// - Request bit rises at start; clearing aborts
// - Fuses 1x disable switching and monitor
// - Switching disabled: fuses pick clock directly
// - Output pin function from fuses; input never I/O
// - Crystal held until 1024 cycles counted, groups 000 and 011 only
module cssm_clock_switch
  import cssm_pkg::*;
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  // Fuses and power events
  input  wire cssm_fuse_t  i_fuse,
  input  wire logic        i_por_bor,         // Power-on/brown-out pulse
  input  wire logic        i_pwrup_expired,   // Power-up delay done
  input  wire logic        i_sleep,
  input  wire logic        i_watchdog_enable, // Software watchdog enable
  // Analog feedback
  input  wire logic        i_osc_running,     // Selected oscillator alive
  input  wire logic        i_osc_tick,        // One crystal cycle seen
  input  wire logic        i_pll_lock,
  // AXI4-Lite slave
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Oscillator controls
  output logic [2:0]       o_clk_group,      // Group steering clock mux
  output logic [1:0]       o_pll_mult,
  output logic [3:0]       o_rc_trim_code,
  output logic             o_lp_crystal_on,
  output logic             o_lp_is_clock,
  output logic             o_slow_rc_on,
  output logic             o_fast_rc_on,
  output logic             o_clock_hold,     // Holds crystal from system
  output logic [4:0]       o_out_pin_mode,   // Output pin function
  output logic             o_fail_trap       // One-cycle trap pulse
);

  // ********************************************
  // State
  // ********************************************
  logic [2:0]  cur_r, req_r;           // Current and requested groups
  logic        lpen_r, fail_r, swreq_r;
  logic [3:0]  trim_r;
  logic        key_lo_r, key_hi_r;     // Unlock windows
  logic        key_lo1_r, key_hi1_r;   // First key seen, window armed
  logic [9:0]  ost_r;                  // Crystal settle counter
  logic        ost_done_r;
  logic        slow_rc_r, trap_r;
  logic        aw_hold_r, w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  cssm_state_t st_r, st_nxt;

  // ********************************************
  // Decoding
  // ********************************************
  wire         sw_ok   = ~i_fuse.switch_monitor_fuses[1];
  wire         mon_on  = (i_fuse.switch_monitor_fuses == 2'h0);
  wire         wr_go   = aw_hold_r & w_hold_r & ~o_bvalid;
  wire         wr_ctrl = wr_go & (awaddr_r == ADDR_CTRL);
  wire         wr_trim = wr_go & (awaddr_r == ADDR_TRIM);
  wire         wr_bad  = wr_go & ~(awaddr_r == ADDR_CTRL | awaddr_r == ADDR_TRIM | awaddr_r == ADDR_STATUS);
  wire [7:0]   wlo     = wdata_r[7:0];
  wire [7:0]   whi     = wdata_r[15:8];
  // Write to a byte lands only inside its unlock window
  wire         lo_wr   = wr_ctrl & wstrb_r[0] & key_lo_r;
  wire         hi_wr   = wr_ctrl & wstrb_r[1] & key_hi_r;
  wire         lo_key1 = wr_ctrl & wstrb_r[0] & ~key_lo_r & (wlo == KEY_LO1);
  wire         hi_key1 = wr_ctrl & wstrb_r[1] & ~key_hi_r & (whi == KEY_HI1);
  wire         lo_key2 = wr_ctrl & wstrb_r[0] & (wlo == KEY_LO2);
  wire         hi_key2 = wr_ctrl & wstrb_r[1] & (whi == KEY_HI2);
  // Group requiring the crystal settle counter
  wire         xtal_grp = (req_r == GRP_LP) | (req_r == GRP_PRI) | (req_r == GRP_PLL);
  wire         pll_grp  = (req_r == GRP_PLL);
  // Source considered ready: running, counted out if crystal, locked if PLL
  wire         src_ready = i_osc_running & (ost_done_r | ~xtal_grp) & (i_pll_lock | ~pll_grp);
  // Failure: lost oscillator, or delay over before it started
  wire         fail_evt = mon_on & i_pwrup_expired & ~i_sleep & ~src_ready & (cur_r != GRP_FRC)
                          & (st_r == SW_IDLE);
  wire [2:0]   grp_eff  = sw_ok ? cur_r : i_fuse.initial_group_fuses;
  logic [1:0]  mult;
  always_comb begin
    // Fast RC fuse codes map to PLL factors; others use primary PLL
    case (i_fuse.primary_choice_fuses)
      FPR_FRC4:  mult = MULT_X4;
      FPR_FRC8:  mult = MULT_X8;
      FPR_FRC16: mult = MULT_X16;
      default:   mult = {1'b0, i_fuse.primary_choice_fuses[0]} + {i_fuse.primary_choice_fuses[1], 1'b0};
    endcase
  end

  // ********************************************
  // Switch sequencer
  // ********************************************
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      SW_IDLE:   if (swreq_r && sw_ok) st_nxt = SW_WAIT;
      SW_WAIT:   if (!swreq_r) st_nxt = SW_IDLE;
                 else if (src_ready) st_nxt = SW_SETTLE;
      SW_SETTLE: st_nxt = SW_IDLE;
      default:   st_nxt = SW_IDLE;
    endcase
  end

  // Sequencer and group registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || i_por_bor) begin
      st_r  <= SW_IDLE;
      cur_r <= i_fuse.initial_group_fuses;
      req_r <= i_fuse.initial_group_fuses;
    end else begin
      st_r <= fail_evt ? SW_IDLE : st_nxt;
      if (fail_evt) cur_r <= GRP_FRC;
      else if (st_r == SW_SETTLE && swreq_r) cur_r <= req_r;
      // Only the five groups are accepted
      if (hi_wr && (whi[2:0] inside {GRP_LP, GRP_FRC, GRP_SLOW_INTERNAL_RC, GRP_PRI, GRP_PLL}))
        req_r <= whi[2:0];
    end
  end

  // Control bits; hardware set wins over software clear
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || i_por_bor) begin
      lpen_r  <= 1'b0;
      fail_r  <= 1'b0;
      swreq_r <= 1'b0;
      trim_r  <= TRIM_RESET;
    end else begin
      if (lo_wr) lpen_r <= wlo[LPEN_BIT];
      if (fail_evt) fail_r <= 1'b1;
      else if (lo_wr && !wlo[FAIL_BIT]) fail_r <= 1'b0;
      if (fail_evt || (st_r == SW_SETTLE)) swreq_r <= 1'b0;
      else if (lo_wr) swreq_r <= wlo[SWREQ_BIT];
      if (wr_trim && wstrb_r[0]) trim_r <= wdata_r[3:0];
    end
  end

  // Unlock windows: first key arms, second key opens, next write closes
  // Any other write disarms, so a lone second key never opens a window
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      key_lo1_r <= 1'b0;
      key_hi1_r <= 1'b0;
      key_lo_r  <= 1'b0;
      key_hi_r  <= 1'b0;
    end else if (wr_go) begin
      // Arm only on the first key of each byte
      key_lo1_r <= lo_key1;
      key_hi1_r <= hi_key1;
      // Open only when the second key follows directly
      key_lo_r  <= key_lo1_r & lo_key2 & ~key_lo_r;
      key_hi_r  <= key_hi1_r & hi_key2 & ~key_hi_r;
    end
  end

  // Crystal settle counter restarts on any switch start
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || i_por_bor || st_r == SW_IDLE && swreq_r) begin
      ost_r      <= '0;
      ost_done_r <= 1'b0;
    end else if (i_osc_tick && !ost_done_r) begin
      ost_r      <= ost_r + 10'h001;
      ost_done_r <= (ost_r == OST_LAST);
    end
  end

  // ********************************************
  // Oscillator outputs
  // ********************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      slow_rc_r       <= 1'b1;
      trap_r          <= 1'b0;
      o_clk_group     <= GRP_FRC;
      o_pll_mult      <= MULT_X1;
      o_rc_trim_code  <= TRIM_RESET;
      o_lp_crystal_on <= 1'b0;
      o_lp_is_clock   <= 1'b0;
      o_fast_rc_on    <= 1'b1;
      o_clock_hold    <= 1'b1;
      o_out_pin_mode  <= '0;
    end else begin
      // Watchdog keeps slow RC need only with monitor off; failure does not touch it
      slow_rc_r <= i_por_bor | ~i_pwrup_expired
                   | (mon_on & ~i_sleep)
                   | (~mon_on & i_watchdog_enable)
                   | (grp_eff == GRP_SLOW_INTERNAL_RC);
      trap_r          <= fail_evt;
      o_clk_group     <= grp_eff;
      o_pll_mult      <= (grp_eff == GRP_PLL) ? mult : MULT_X1;
      o_rc_trim_code  <= trim_r;
      o_lp_crystal_on <= lpen_r;
      o_lp_is_clock   <= (grp_eff == GRP_LP) & lpen_r;
      o_fast_rc_on    <= (grp_eff == GRP_FRC) | (req_r == GRP_FRC);
      o_clock_hold    <= ~ost_done_r & (grp_eff == GRP_LP | grp_eff == GRP_PRI);
      o_out_pin_mode  <= i_fuse.primary_choice_fuses;
    end
  end
  assign o_slow_rc_on = slow_rc_r;
  assign o_fail_trap  = trap_r;

  // ********************************************
  // AXI4-Lite slave
  // ********************************************
  wire [31:0] ctrl_rd = {16'h0000, 1'b0, cur_r, 1'b0, req_r, 2'b00, i_pll_lock, 1'b0,
                         fail_r, 1'b0, lpen_r, swreq_r};
  wire [31:0] stat_rd = {28'h0000000, o_clock_hold, slow_rc_r, st_r};
  wire        rd_ok   = (i_araddr == ADDR_CTRL) | (i_araddr == ADDR_TRIM) | (i_araddr == ADDR_STATUS);
  wire [31:0] rd_mux  = (i_araddr == ADDR_CTRL) ? ctrl_rd :
                        (i_araddr == ADDR_TRIM) ? {28'h0000000, trim_r} :
                        (i_araddr == ADDR_STATUS) ? stat_rd : 32'h00000000;

  // Address and data captured independently
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      o_bvalid  <= 1'b0;
      o_bresp   <= RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= i_awaddr;
      end else if (wr_go) aw_hold_r <= 1'b0;
      if (i_wvalid && o_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= i_wdata;
        wstrb_r  <= i_wstrb;
      end else if (wr_go) w_hold_r <= 1'b0;
      if (wr_go) begin
        o_bvalid <= 1'b1;
        o_bresp  <= wr_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (i_bready) o_bvalid <= 1'b0;
    end
  end
  assign o_awready = ~aw_hold_r & ~o_bvalid;
  assign o_wready  = ~w_hold_r & ~o_bvalid;

  // Read answered one cycle after the address is taken
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_rvalid <= 1'b0;
      o_rdata  <= '0;
      o_rresp  <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata  <= rd_mux;
      o_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (i_rready) o_rvalid <= 1'b0;
  end
  assign o_arready = ~o_rvalid;

  // ********************************************
  // Checks
  // ********************************************
  a_fail_loads_frc: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    fail_evt && !i_por_bor |=> cur_r == GRP_FRC && fail_r && !swreq_r) else $error("fail handling wrong");
  a_trap_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    fail_evt |=> o_fail_trap) else $error("trap missing");
  a_no_switch_off: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !sw_ok && !i_por_bor |=> $stable(cur_r) || cur_r == GRP_FRC) else $error("switch while disabled");
  a_lp_clock: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    ##1 o_lp_is_clock |-> $past(lpen_r)) else $error("crystal clock without enable");
  a_abort_clear: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    st_r == SW_WAIT && !swreq_r |=> st_r == SW_IDLE) else $error("abort ignored");
  a_done_copies: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    st_r == SW_SETTLE && swreq_r && !fail_evt && !i_por_bor |=> cur_r == $past(req_r) && !swreq_r)
    else $error("switch not completed");
  a_slow_rc_mon: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    mon_on && !i_sleep |=> o_slow_rc_on) else $error("slow rc off with monitor");
  a_trim_out: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    wr_trim && wstrb_r[0] && !i_por_bor |=> ##1 o_rc_trim_code == $past(wdata_r[3:0], 2)) else $error("trim lost");

  // Switch steps: request taken while idle
  sequence s_sw_start;
    st_r == SW_IDLE && swreq_r && sw_ok && !fail_evt && !i_por_bor;
  endsequence
  // Switch steps: new source running and settled
  sequence s_sw_ready;
    st_r == SW_WAIT && swreq_r && src_ready && !i_por_bor;
  endsequence
  // Switch steps: still waiting for the source
  sequence s_sw_waiting;
    st_r == SW_WAIT && swreq_r && !src_ready && !i_por_bor;
  endsequence

  // Request starts the sequencer
  a_start_wait: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    s_sw_start |=> st_r == SW_WAIT)
    else $error("switch not started");
  // Settled source moves on to the copy step
  a_ready_settle: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    s_sw_ready |=> st_r == SW_SETTLE)
    else $error("settled source ignored");
  // No copy before the source is ready; avoids a clock glitch
  a_wait_held: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    s_sw_waiting |=> st_r == SW_WAIT && $stable(cur_r))
    else $error("switch before source ready");
  // Crystal held from the system until counted out
  a_hold_xtal: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !ost_done_r && (grp_eff == GRP_LP || grp_eff == GRP_PRI) |=> o_clock_hold)
    else $error("crystal released early");
  // Slow RC always on after a power event
  a_slow_por: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_por_bor |=> o_slow_rc_on)
    else $error("slow rc off at power-on");
  // No trap with the monitor disabled
  a_no_trap_off: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !mon_on |=> !o_fail_trap)
    else $error("trap with monitor off");
  // Crystal kept running, sleep or not, while enabled
  a_lp_on: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    lpen_r |=> o_lp_crystal_on)
    else $error("crystal stopped while enabled");
  // Fast RC sixteen-times code reaches the PLL
  a_pll_x16: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    grp_eff == GRP_PLL && i_fuse.primary_choice_fuses == FPR_FRC16 |=> o_pll_mult == MULT_X16)
    else $error("pll factor wrong");
  // Group 001 steers the mux to fast RC
  a_sel_frc: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    grp_eff == GRP_FRC |=> o_clk_group == GRP_FRC && o_fast_rc_on)
    else $error("fast rc not selected");
endmodule

// >>> cssm_pkg.sv
package cssm_pkg;
  // ********************************************
  // Register map (byte addresses)
  // ********************************************
  localparam logic [7:0]  ADDR_CTRL       = 8'h00; // Clock control register
  localparam logic [7:0]  ADDR_TRIM       = 8'h04; // RC trim register
  localparam logic [7:0]  ADDR_STATUS     = 8'h08; // Side status bits
  // ********************************************
  // Clock control field positions
  // ********************************************
  localparam int CUR_LSB   = 12;  // Current group 14:12
  localparam int REQ_LSB   = 8;   // Requested group 10:8
  localparam int LOCK_BIT  = 5;   // PLL lock, read only
  localparam int FAIL_BIT  = 3;   // Clock fail flag
  localparam int LPEN_BIT  = 1;   // Low-power crystal enable
  localparam int SWREQ_BIT = 0;   // Switch request bit
  // ********************************************
  // Groups, fuse codes, unlock keys
  // ********************************************
  localparam logic [2:0] GRP_LP   = 3'h0; // Secondary crystal
  localparam logic [2:0] GRP_FRC  = 3'h1; // Fast internal RC
  localparam logic [2:0] GRP_SLOW_INTERNAL_RC = 3'h2; // Slow internal RC
  localparam logic [2:0] GRP_PRI  = 3'h3; // Primary, no PLL
  localparam logic [2:0] GRP_PLL  = 3'h7; // Primary with PLL
  localparam logic [4:0] FPR_FRC4  = 5'h01; // Fast RC x4
  localparam logic [4:0] FPR_FRC8  = 5'h0a; // Fast RC x8
  localparam logic [4:0] FPR_FRC16 = 5'h03; // Fast RC x16
  localparam logic [7:0] KEY_LO1 = 8'h46;
  localparam logic [7:0] KEY_LO2 = 8'h57;
  localparam logic [7:0] KEY_HI1 = 8'h78;
  localparam logic [7:0] KEY_HI2 = 8'h9a;
  localparam logic [1:0] MULT_X1  = 2'h0; // PLL factor codes
  localparam logic [1:0] MULT_X4  = 2'h1;
  localparam logic [1:0] MULT_X8  = 2'h2;
  localparam logic [1:0] MULT_X16 = 2'h3;
  localparam logic [9:0] OST_LAST = 10'h3ff; // 1024 crystal cycles
  localparam logic [3:0] TRIM_RESET = 4'h0;   // Calibrated centre
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Fuse bundle
  typedef struct packed {
    logic [1:0] switch_monitor_fuses;
    logic [2:0] initial_group_fuses;
    logic [4:0] primary_choice_fuses;
  } cssm_fuse_t;

  // Switch sequencer states
  typedef enum logic [1:0] {
    SW_IDLE   = 2'b00,
    SW_WAIT   = 2'b01,
    SW_SETTLE = 2'b10
  } cssm_state_t;
endpackage

// >>> tb_clock_source_switch_monitor.sv
`timescale 1ns/1ps
module tb_clock_source_switch_monitor
  import cssm_pkg::*;
  ;
  // ********************************************
  // Stimulus and observed signals
  // ********************************************
  logic        i_ref_clk, i_reset_n, i_por_bor, i_pwrup_expired, i_sleep, i_watchdog_enable;
  logic        i_osc_running, i_osc_tick, i_pll_lock;
  cssm_fuse_t  i_fuse;
  logic [7:0]  i_awaddr, i_araddr;
  logic [31:0] i_wdata;
  logic [3:0]  i_wstrb;
  logic        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]  o_bresp, o_rresp, o_pll_mult, resp;
  logic [31:0] o_rdata, rd;
  logic [2:0]  o_clk_group;
  logic [3:0]  o_rc_trim_code;
  logic        o_lp_crystal_on, o_lp_is_clock, o_slow_rc_on, o_fast_rc_on, o_clock_hold, o_fail_trap;
  logic [4:0]  o_out_pin_mode;
  logic        tick_en, lpen;                  // Crystal tick gate, enable bit shadow
  int          n_fail, checks_done;

  cssm_clock_switch cssm_clock_switch_inst (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_fuse(i_fuse), .i_por_bor(i_por_bor),
    .i_pwrup_expired(i_pwrup_expired), .i_sleep(i_sleep), .i_watchdog_enable(i_watchdog_enable),
    .i_osc_running(i_osc_running), .i_osc_tick(i_osc_tick), .i_pll_lock(i_pll_lock),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
    .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .o_clk_group(o_clk_group), .o_pll_mult(o_pll_mult), .o_rc_trim_code(o_rc_trim_code),
    .o_lp_crystal_on(o_lp_crystal_on), .o_lp_is_clock(o_lp_is_clock), .o_slow_rc_on(o_slow_rc_on),
    .o_fast_rc_on(o_fast_rc_on), .o_clock_hold(o_clock_hold), .o_out_pin_mode(o_out_pin_mode),
    .o_fail_trap(o_fail_trap));

  // 100 MHz clock
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // Crystal ticks at half the bus rate; stop to starve the settle counter
  always @(posedge i_ref_clk) begin
    i_osc_tick <= tick_en & ~i_osc_tick;
  end

  // ********************************************
  // Shared helpers
  // ********************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask

  // AXI4-Lite write; address and data released each at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int   n;
    logic aw_ok;
    logic w_ok;
    @(posedge i_ref_clk);
    i_awaddr  <= a;
    i_wdata   <= d;
    i_wstrb   <= s;
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_bready  <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    n = 0;
    while (!(aw_ok && w_ok) && n < 100) begin
      @(posedge i_ref_clk);
      n++;
      if (!aw_ok && o_awready === 1'b1) begin
        aw_ok = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (!w_ok && o_wready === 1'b1) begin
        w_ok = 1'b1;
        i_wvalid <= 1'b0;
      end
    end
    // Response always trails both halves, so wait from the next edge
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_bvalid !== 1'b1 && n < 200);
    resp = o_bresp;
    i_bready <= 1'b0;
    if (n >= 200) n_fail++;
  endtask

  // AXI4-Lite read; data taken at the edge that sees rvalid
  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge i_ref_clk);
    i_araddr  <= a;
    i_arvalid <= 1'b1;
    i_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
      if (o_arready === 1'b1) i_arvalid <= 1'b0;
    end while (o_arready !== 1'b1 && n < 100);
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_rvalid !== 1'b1 && n < 200);
    rd = o_rdata;
    resp = o_rresp;
    i_rready <= 1'b0;
    if (n >= 200) n_fail++;
  endtask

  // Unlocked byte writes to the control register
  task automatic lo(input logic [7:0] v);
    wr(ADDR_CTRL, {24'h0, KEY_LO1}, 4'h1);
    wr(ADDR_CTRL, {24'h0, KEY_LO2}, 4'h1);
    wr(ADDR_CTRL, {24'h0, v}, 4'h1);
  endtask

  task automatic hi(input logic [7:0] v);
    wr(ADDR_CTRL, {16'h0, KEY_HI1, 8'h0}, 4'h2);
    wr(ADDR_CTRL, {16'h0, KEY_HI2, 8'h0}, 4'h2);
    wr(ADDR_CTRL, {16'h0, v, 8'h0}, 4'h2);
  endtask

  // Request a group and poll until the request bit drops
  task automatic sw_to(input logic [2:0] g);
    int n;
    hi({5'h0, g});
    lo({6'h0, lpen, 1'b1});
    n = 0;
    do begin
      rdr(ADDR_CTRL);
      n++;
    end while (rd[SWREQ_BIT] !== 1'b0 && n < 1500);
    chk("group after switch", rd[14:12], g);
  endtask

  // ********************************************
  // Scenarios
  // ********************************************
  task automatic t_reset();
    rdr(ADDR_CTRL);
    chk("current group", rd[14:12], GRP_PRI);
    chk("requested group", rd[10:8], GRP_PRI);
    chk("request and fail", {rd[FAIL_BIT], rd[SWREQ_BIT]}, 2'b00);
    chk("slow rc at reset", o_slow_rc_on, 1'b1);
    chk("pin mode", o_out_pin_mode, 5'h04);
    chk("crystal held", o_clock_hold, 1'b1);
    rdr(8'h40);
    chk("unmapped resp", resp, RESP_SLVERR);
  endtask

  task automatic t_lock_trim();
    i_pll_lock <= 1'b0;
    rdr(ADDR_CTRL);
    chk("lock low", rd[LOCK_BIT], 1'b0);
    i_pll_lock <= 1'b1;
    rdr(ADDR_CTRL);
    chk("lock high", rd[LOCK_BIT], 1'b1);
    rdr(ADDR_TRIM);
    chk("trim reset", rd, {28'h0, TRIM_RESET});
    wr(ADDR_TRIM, 32'h8, 4'hf);
    rdr(ADDR_TRIM);
    chk("trim low end", {rd[3:0], o_rc_trim_code}, 8'h88);
    wr(ADDR_TRIM, 32'h7, 4'hf);
    rdr(ADDR_TRIM);
    chk("trim high end", {rd[3:0], o_rc_trim_code}, 8'h77);
  endtask

  task automatic t_lp();
    wr(ADDR_CTRL, 32'h2, 4'h1);
    rdr(ADDR_CTRL);
    chk("locked write ignored", rd[LPEN_BIT], 1'b0);
    lpen = 1'b1;
    lo(8'h02);
    i_sleep <= 1'b1;
    cyc(4);
    chk("crystal on in sleep", o_lp_crystal_on, 1'b1);
    chk("crystal not clock", o_lp_is_clock, 1'b0);
    i_sleep <= 1'b0;
    // Slow crystal only with the monitor off
    i_fuse.switch_monitor_fuses <= 2'b01;
    sw_to(GRP_LP);
    chk("crystal is clock", o_lp_is_clock, 1'b1);
    sw_to(GRP_FRC);
    chk("fast rc group", o_clk_group, GRP_FRC);
    chk("fast rc on", o_fast_rc_on, 1'b1);
    i_fuse.switch_monitor_fuses <= 2'b00;
  endtask

  task automatic t_pll();
    logic [4:0] code [3] = '{FPR_FRC4, FPR_FRC8, FPR_FRC16};
    logic [1:0] mult [3] = '{MULT_X4, MULT_X8, MULT_X16};
    // Trim back to centre before the x4, x8 and x16 factors
    wr(ADDR_TRIM, {28'h0, TRIM_RESET}, 4'hf);
    for (int i = 0; i < 3; i++) begin
      i_fuse.primary_choice_fuses <= code[i];
      sw_to(GRP_PLL);
      chk("pll factor", o_pll_mult, mult[i]);
      sw_to(GRP_FRC);
    end
    i_fuse.primary_choice_fuses <= 5'h04;
  endtask

  task automatic t_abort();
    tick_en <= 1'b0;
    hi({5'h0, GRP_PRI});
    lo({6'h0, lpen, 1'b1});
    cyc(20);
    lo({6'h0, lpen, 1'b0});
    tick_en <= 1'b1;
    cyc(2200);
    rdr(ADDR_CTRL);
    chk("aborted switch", {rd[14:12], rd[SWREQ_BIT]}, {GRP_FRC, 1'b0});
  endtask

  task automatic t_fail();
    int n;
    sw_to(GRP_PRI);
    chk("crystal released", o_clock_hold, 1'b0);
    i_osc_running   <= 1'b0;
    i_pwrup_expired <= 1'b1;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_fail_trap !== 1'b1 && n < 50);
    chk("trap raised", n < 50, 1'b1);
    rdr(ADDR_CTRL);
    chk("fail state", {rd[14:12], rd[FAIL_BIT], rd[SWREQ_BIT]}, {GRP_FRC, 2'b10});
    chk("slow rc kept", o_slow_rc_on, 1'b1);
    i_osc_running <= 1'b1;
  endtask

  task automatic t_fuse_off();
    int seen;
    i_fuse <= '{2'b10, GRP_PRI, 5'h04};
    i_por_bor <= 1'b1;
    cyc(1);
    i_por_bor <= 1'b0;
    cyc(6);
    chk("direct fuse group", o_clk_group, GRP_PRI);
    chk("slow rc off", o_slow_rc_on, 1'b0);
    i_watchdog_enable <= 1'b1;
    cyc(4);
    chk("slow rc for watchdog", o_slow_rc_on, 1'b1);
    hi({5'h0, GRP_FRC});
    lo(8'h01);
    cyc(50);
    rdr(ADDR_CTRL);
    chk("switch disabled", rd[14:12], GRP_PRI);
    i_osc_running <= 1'b0;
    seen = 0;
    repeat (40) begin
      @(posedge i_ref_clk);
      if (o_fail_trap !== 1'b0) seen++;
    end
    chk("monitor disabled", seen, 0);
  endtask

  // ********************************************
  // Main sequence and watchdog
  // ********************************************
  initial begin
    {i_reset_n, i_por_bor, i_pwrup_expired, i_sleep, i_watchdog_enable} = 5'h0;
    {i_osc_running, i_pll_lock, tick_en, i_osc_tick, lpen} = 5'h1c;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h0;
    {i_awaddr, i_araddr, i_wdata, i_wstrb} = '0;
    i_fuse = '{2'b00, GRP_PRI, 5'h04};
    n_fail = 0;
    checks_done = 0;
    cyc(8);
    i_reset_n <= 1'b1;
    t_reset();
    t_lock_trim();
    t_lp();
    t_pll();
    t_abort();
    t_fail();
    t_fuse_off();
    test_done();
  end

  // Hang guard, far beyond the expected span of the switches
  initial begin
    #900000;
    n_fail++;
    test_done();
  end
endmodule
